// *** rtl/masd_decode.sv ***
/*
 * Address space decoder for the internal module bus: places the module
 * control register block, zero-fills unused locations and bits, routes
 * unused addresses off chip, guards supervisor-only slots and forms
 * exception vector addresses.
 * Assumes module read data and its implemented-bit mask are valid in the
 * cycle of the request, and that inputs are synchronous to clock.
 */
`timescale 1ns/1ps

module masd_decode #(
	parameter logic [31:0] SLOT_MAP   = masd_pkg::SLOT_MAP_RESET,
	parameter logic [15:0] SUPER_ONLY = masd_pkg::SUPER_ONLY_RESET
) (
	input  wire logic                           clock,
	input  wire logic                           resetn,
	input  wire masd_pkg::masd_req_t            busReq,
	input  wire logic [masd_pkg::DATA_W-1:0]    moduleRdata,
	input  wire logic [masd_pkg::DATA_W-1:0]    moduleBitMask,
	input  wire logic                           mapWrite,
	input  wire logic                           mapValue,
	input  wire logic [31:0]                    vector_base_register,
	input  wire masd_pkg::masd_vreq_t           vecReq,
	output masd_pkg::masd_rsp_t                 busRsp,
	output masd_pkg::masd_vrsp_t                vecRsp,
	output logic                                module_map_signal
);

	// ******************************************************
	// Decode helpers
	// ******************************************************
	function automatic logic inBlock(input logic [23:0] a, input logic m);
		inBlock = (a[23:20] == {m, masd_pkg::BLOCK_LOW_BITS});
	endfunction

	function automatic logic [1:0] slotClass(input logic [23:0] a);
		if (a[19:12] != masd_pkg::REG_AREA_PAGE) begin
			slotClass = masd_pkg::SLOT_EXTERNAL;
		end else begin
			slotClass = SLOT_MAP[{a[11:8], 1'b0} +: 2];
		end
	endfunction

	// ******************************************************
	// Module-map bit
	// ******************************************************
	logic module_map_bit_r;
	logic module_map_bit_nxt;

	always_comb begin
		module_map_bit_nxt = module_map_bit_r;
		if (mapWrite) begin
			module_map_bit_nxt = mapValue;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			module_map_bit_r <= masd_pkg::MAP_RESET;
		end else begin
			module_map_bit_r <= module_map_bit_nxt;
		end
	end

	assign module_map_signal = module_map_bit_r;

	// ******************************************************
	// Bus access decode
	// ******************************************************
	masd_pkg::masd_rsp_t busRsp_r;
	masd_pkg::masd_rsp_t busRsp_nxt;
	logic                hit;
	logic [1:0]          cls;
	logic                userSpace;

	always_comb begin
		hit        = inBlock(busReq.addr, module_map_bit_r);
		cls        = slotClass(busReq.addr);
		userSpace  = !busReq.accessSpaceCode[masd_pkg::SPACE_SUPER_BIT];
		busRsp_nxt = '0;
		busRsp_nxt.valid = busReq.valid;
		if (busReq.valid) begin
			if (!hit) begin
				busRsp_nxt.toExternal = 1'b1;
			end else begin
				case (cls)
					masd_pkg::SLOT_USED: begin
						if (userSpace && SUPER_ONLY[busReq.addr[11:8]]) begin
							busRsp_nxt.busError = 1'b1;
						end else begin
							busRsp_nxt.toInternal = 1'b1;
							if (!busReq.write) begin
								busRsp_nxt.rdata = moduleRdata & moduleBitMask;
							end
						end
					end
					masd_pkg::SLOT_ZERO: begin
						busRsp_nxt.toInternal = 1'b1;
					end
					masd_pkg::SLOT_EXTERNAL: begin
						busRsp_nxt.toExternal = 1'b1;
					end
					masd_pkg::SLOT_RESERVED: begin
						busRsp_nxt.busError = 1'b1;
					end
					default: begin
						busRsp_nxt.busError = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			busRsp_r <= '0;
		end else begin
			busRsp_r <= busRsp_nxt;
		end
	end

	assign busRsp = busRsp_r;

	// ******************************************************
	// Exception vector address
	// ******************************************************
	masd_pkg::masd_vrsp_t vecRsp_r;
	masd_pkg::masd_vrsp_t vecRsp_nxt;

	always_comb begin
		vecRsp_nxt       = '0;
		vecRsp_nxt.valid = vecReq.valid;
		if (vecReq.valid) begin
			if (vecReq.isReset) begin
				vecRsp_nxt.addr            = masd_pkg::RESET_VEC_ADDR;
				vecRsp_nxt.accessSpaceCode = masd_pkg::SPACE_SUPER_PROG;
			end else begin
				vecRsp_nxt.addr = {vector_base_register[31:masd_pkg::BASE_KEEP_LSB],
					vecReq.number, 2'h0};
				vecRsp_nxt.accessSpaceCode = masd_pkg::SPACE_SUPER_DATA;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			vecRsp_r <= '0;
		end else begin
			vecRsp_r <= vecRsp_nxt;
		end
	end

	assign vecRsp = vecRsp_r;

	// ******************************************************
	// Assertions
	// ******************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_block_nibble;
		busReq.valid && busReq.addr[22:20] != 3'h7 |=> busRsp.toExternal && !busRsp.toInternal;
	endproperty
	a_block_nibble: assert property (p_block_nibble) else $error("non-block nibble not routed out");

	property p_zero_slot;
		busReq.valid && !busReq.write && inBlock(busReq.addr, module_map_bit_r)
			&& slotClass(busReq.addr) == masd_pkg::SLOT_ZERO |=> busRsp.rdata == '0;
	endproperty
	a_zero_slot: assert property (p_zero_slot) else $error("unused location read nonzero");

	property p_vec_space;
		vecReq.valid |=> vecRsp.accessSpaceCode ==
			($past(vecReq.isReset) ? masd_pkg::SPACE_SUPER_PROG : masd_pkg::SPACE_SUPER_DATA);
	endproperty
	a_vec_space: assert property (p_vec_space) else $error("vector fetched from wrong space");

	property p_reset_fixed;
		vecReq.valid && vecReq.isReset |=> vecRsp.addr == masd_pkg::RESET_VEC_ADDR;
	endproperty
	a_reset_fixed: assert property (p_reset_fixed) else $error("reset vector not at fixed address");

	property p_vec_addr;
		vecReq.valid && !vecReq.isReset |=> vecRsp.addr[9:0] == {$past(vecReq.number), 2'h0}
			&& vecRsp.addr[31:10] == $past(vector_base_register[31:10]);
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector address badly formed");

	property p_reserved_local;
		busReq.valid && inBlock(busReq.addr, module_map_bit_r)
			&& slotClass(busReq.addr) == masd_pkg::SLOT_RESERVED |=> busRsp.busError && !busRsp.toExternal;
	endproperty
	a_reserved_local: assert property (p_reserved_local) else $error("reserved block sent off chip");

	property p_user_refused;
		busReq.valid && !busReq.accessSpaceCode[2] && inBlock(busReq.addr, module_map_bit_r)
			&& slotClass(busReq.addr) == masd_pkg::SLOT_USED && SUPER_ONLY[busReq.addr[11:8]]
			|=> busRsp.busError && !busRsp.toInternal;
	endproperty
	a_user_refused: assert property (p_user_refused) else $error("user access reached supervisor register");

	property p_map_next;
		mapWrite ##1 busReq.valid |-> inBlock(busReq.addr, $past(mapValue)) == hit;
	endproperty
	a_map_next: assert property (p_map_next) else $error("module map change not applied");

	property p_unused_bits;
		busReq.valid && !busReq.write |=> (busRsp.rdata & ~$past(moduleBitMask)) == '0;
	endproperty
	a_unused_bits: assert property (p_unused_bits) else $error("unimplemented bit read nonzero");

	property p_one_target;
		busRsp.valid |-> $onehot({busRsp.toInternal, busRsp.toExternal, busRsp.busError});
	endproperty
	a_one_target: assert property (p_one_target) else $error("access routed to more than one target");

	c_internal: cover property (busReq.valid ##1 busRsp.toInternal);
	c_external: cover property (busReq.valid && hit ##1 busRsp.toExternal);
	c_vector:   cover property (vecReq.valid && !vecReq.isReset ##1 vecRsp.valid);
	c_remap:    cover property (mapWrite && mapValue != module_map_bit_r ##1 busReq.valid);
	c_refused:  cover property (busReq.valid ##1 busRsp.busError);

endmodule

// *** rtl/masd_pkg.sv ***
/*
 * Constants and carrier types for the module address space decoder.
 * Assumes a 24-bit internal module bus address, 16-bit data and a
 * 3-bit access space code from the processor core.
 */
// Notes on behaviour
// - Register block decodes where address bits 23..20 equal the module-map bit then 111.
// - Unused locations and unused bits inside the register area read as zero.
// - Vectors come from supervisor data space; reset vector from supervisor program.
// - Only reset vector is fixed; others sit relative to the vector base.
// - Vector address is upper 22 vector-base bits, vector number, two zero bits.
// - Unused register-block addresses go off chip; reserved blocks never do.
// - Some internal registers refuse accesses made in user space.
package masd_pkg;

	localparam int          ADDR_W          = 24;
	localparam int          DATA_W          = 16;
	localparam int          SLOT_CNT        = 16;

	// Register block select nibble: {module_map_bit, 3'b111}
	localparam logic [2:0]  BLOCK_LOW_BITS  = 3'h7;
	// Register area inside the selected megabyte, addr[19:12]
	localparam logic [7:0]  REG_AREA_PAGE   = 8'hff;
	localparam logic        MAP_RESET       = 1'h1;

	// Slot classes, 2 bits per slot of 256 bytes, slot = addr[11:8]
	localparam logic [1:0]  SLOT_USED       = 2'h0;
	localparam logic [1:0]  SLOT_ZERO       = 2'h1;
	localparam logic [1:0]  SLOT_EXTERNAL   = 2'h2;
	localparam logic [1:0]  SLOT_RESERVED   = 2'h3;
	localparam logic [31:0] SLOT_MAP_RESET  = 32'h0f7d_9c40;
	localparam logic [15:0] SUPER_ONLY_RESET = 16'h8001;

	// Access space codes
	localparam logic [2:0]  SPACE_SUPER_DATA = 3'h5;
	localparam logic [2:0]  SPACE_SUPER_PROG = 3'h6;
	localparam int          SPACE_SUPER_BIT  = 2;

	localparam int          BASE_KEEP_LSB   = 10;
	localparam logic [31:0] RESET_VEC_ADDR  = 32'h0000_0000;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [2:0]        accessSpaceCode;
		logic [ADDR_W-1:0] addr;
	} masd_req_t;

	typedef struct packed {
		logic              valid;
		logic              toInternal;
		logic              toExternal;
		logic              busError;
		logic [DATA_W-1:0] rdata;
	} masd_rsp_t;

	typedef struct packed {
		logic       valid;
		logic       isReset;
		logic [7:0] number;
	} masd_vreq_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  accessSpaceCode;
		logic [31:0] addr;
	} masd_vrsp_t;

endpackage

// *** test/masd_mod_model.sv ***
/*
 * Model of what stands beyond the decoder: the internal modules and the
 * external space decode in its three wirings.
 * Assumes data and mask must be valid in the request cycle.
 */
`timescale 1ns/1ps

module masd_mod_model (
	input  wire logic [23:0] addr,
	input  wire logic [2:0]  spaceCode,
	output logic      [15:0] rdata,
	output logic      [15:0] mask,
	output logic      [1:0]  spaceOne,
	output logic      [1:0]  spaceTwo,
	output logic      [1:0]  spaceFour
);
	// Data and implemented bits follow the address, so slots differ
	assign rdata = {addr[11:4], ~addr[11:4]};
	assign mask  = {4'hf, addr[11:8], 8'h5a};

	// Space index seen by external logic: code lines ignored, top line only, top two lines
	assign spaceOne  = 2'h0;
	assign spaceTwo  = {1'h0, spaceCode[2]};
	assign spaceFour = {spaceCode[2], spaceCode[1]};
endmodule

// *** test/masd_decode_tb.sv ***
/*
 * Self-checking bench for the module address space decoder.
 * Assumes the internal module model answers in the request cycle.
 */
`timescale 1ns/1ps

module masd_decode_tb;
	logic                 clock    = 1'h0;
	logic                 resetn   = 1'h0;
	masd_pkg::masd_req_t  busReq   = '0;
	masd_pkg::masd_vreq_t vecReq   = '0;
	logic                 mapWrite = 1'h0;
	logic                 mapValue = 1'h0;
	logic [31:0]          vecBase  = 32'h0;
	logic [1:0]           spOne;
	logic [1:0]           spTwo;
	logic [1:0]           spFour;
	logic [15:0]          mRdata;
	logic [15:0]          mMask;
	masd_pkg::masd_rsp_t  busRsp;
	masd_pkg::masd_vrsp_t vecRsp;
	logic                 mapSig;
	int                   num_errors = 0;
	int                   n_compared = 0;

	always #5 clock = ~clock;

	masd_mod_model PART (
		.addr(busReq.addr), .spaceCode(vecRsp.accessSpaceCode), .rdata(mRdata), .mask(mMask),
		.spaceOne(spOne), .spaceTwo(spTwo), .spaceFour(spFour)
	);

	masd_decode DUT (
		.clock(clock), .resetn(resetn), .busReq(busReq), .moduleRdata(mRdata),
		.moduleBitMask(mMask), .mapWrite(mapWrite), .mapValue(mapValue),
		.vector_base_register(vecBase), .vecReq(vecReq), .busRsp(busRsp),
		.vecRsp(vecRsp), .module_map_signal(mapSig)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One access; the answer is looked at just after the following edge
	task automatic access(input logic [23:0] a, input logic [2:0] sp, input logic wr);
		@(posedge clock);
		busReq <= '{1'h1, wr, sp, a};
		@(posedge clock);
		busReq.valid <= 1'h0;
		#1;
	endtask

	task automatic slot_classes();
		logic [1:0] c;
		for (int s = 0; s < 16; s++) begin
			c = masd_pkg::SLOT_MAP_RESET[2*s +: 2];
			access({12'hfff, s[3:0], 8'h24}, 3'h5, 1'h0);
			check(busRsp.toInternal, c == 2'h0 || c == 2'h1);
			check(busRsp.toExternal, c == 2'h2);
			check(busRsp.busError, c == 2'h3);
			check(busRsp.rdata, (c == 2'h0) ? (mRdata & mMask) : 16'h0);
		end
	endtask

	task automatic user_guard();
		access(24'hfff000, 3'h1, 1'h0);
		check(busRsp.busError, 1'h1);
		check(busRsp.rdata, 16'h0);
		access(24'hfff100, 3'h1, 1'h0);
		check(busRsp.busError, 1'h0);
		check(busRsp.rdata, mRdata & mMask);
	endtask

	task automatic outside_block();
		access(24'h7ff100, 3'h5, 1'h0);
		check(busRsp.toExternal, 1'h1);
		access(24'hfef100, 3'h5, 1'h0);
		check(busRsp.toExternal, 1'h1);
		access(24'hfff100, 3'h5, 1'h1);
		check(busRsp.toInternal, 1'h1);
		check(busRsp.rdata, 16'h0);
		@(posedge clock);
		#1;
		check(busRsp.valid, 1'h0);
	endtask

	task automatic map_move();
		@(posedge clock);
		mapWrite <= 1'h1;
		busReq <= '{1'h1, 1'h0, 3'h5, 24'hfff100};
		@(posedge clock);
		mapWrite <= 1'h0;
		busReq.addr <= 24'h7ff100;
		#1;
		check(busRsp.toInternal, 1'h1);
		check(mapSig, 1'h0);
		@(posedge clock);
		busReq.valid <= 1'h0;
		#1;
		check(busRsp.toInternal, 1'h1);
		access(24'h7ff100, 3'h5, 1'h0);
		check(busRsp.toInternal, 1'h1);
		access(24'hfff100, 3'h5, 1'h0);
		check(busRsp.toExternal, 1'h1);
		@(posedge clock);
		mapWrite <= 1'h1;
		mapValue <= 1'h1;
		@(posedge clock);
		mapWrite <= 1'h0;
		#1;
		check(mapSig, 1'h1);
	endtask

	task automatic vectors();
		@(posedge clock);
		vecBase <= 32'h1234_57ff;
		vecReq <= '{1'h1, 1'h0, 8'hff};
		@(posedge clock);
		vecBase <= 32'hfedc_bbff;
		vecReq <= '{1'h1, 1'h0, 8'h01};
		#1;
		check(vecRsp.valid, 1'h1);
		check(vecRsp.addr, 32'h1234_57fc);
		check(vecRsp.accessSpaceCode, 3'h5);
		check(spFour, 2'h2);
		check(spTwo, 2'h1);
		@(posedge clock);
		vecReq <= '{1'h1, 1'h1, 8'h33};
		#1;
		check(vecRsp.addr, 32'hfedc_b804);
		@(posedge clock);
		vecReq.valid <= 1'h0;
		#1;
		check(vecRsp.addr, 32'h0);
		check(vecRsp.accessSpaceCode, 3'h6);
		check(spFour, 2'h3);
		check(spTwo, 2'h1);
		check(spOne, 2'h0);
		@(posedge clock);
		#1;
		check(vecRsp.valid, 1'h0);
	endtask

	initial begin
		repeat (16) @(posedge clock);
		check(mapSig, 1'h1);
		resetn <= 1'h1;
		slot_classes();
		user_guard();
		outside_block();
		map_move();
		vectors();
		report_and_stop();
	end
endmodule
